// ---- gtap_top.sv ----
// AHB-Lite register slave giving indirect access to the three gamma tables.
// Assumes a single master, single word transfers and one clock for all logic.
//
// Notes on behaviour
// - Increment mode: never, reads, writes, or both
// - Selection: all tables, red, green, blue
// - Three tables share one address, data port
// - Address port read/write, clears to zero
// - Data port writes/reads selected entry, no reset
// - Page bit at top index of both pages
// - Red, green, blue enables in bits 7-5
`timescale 1ns/1ns
`default_nettype none
module gtap_top
	import gtap_pkg::*;
(
	// Clock, reset, enable
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic ce,
	// AHB-Lite slave
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata,
	// Gamma correction enables
	output logic gamma_red_en,
	output logic gamma_green_en,
	output logic gamma_blue_en
);
	typedef enum logic [2:0] {
		ST_IDLE,
		ST_WRITE,
		ST_RD_MEM,
		ST_RD_LOAD,
		ST_RD_DONE
	} gtap_state_type;

	gtap_state_type state_q;
	gtap_state_type state_d;

	logic taken;
	logic [7:0] idx_q;
	logic ok_q;
	logic [7:0] ctrl_q;
	logic page_q;
	logic hreadyout_q;
	logic hresp_q;
	logic [31:0] hrdata_q;
	logic [7:0] ptr;
	logic hit_page;
	logic low_page;
	logic hit_ctrl;
	logic hit_addr;
	logic hit_data;
	logic wr_phase;
	logic rd_issue;
	logic [1:0] sel;
	logic [2:0] tbl_we;
	logic [1:0] rd_tbl;
	logic [7:0] rbyte;

	gtap_mem_if mem_bus ();

	// Address phase
	assign taken = ce && hsel && htrans[1] && hready;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			idx_q <= GTAP_ZERO;
			ok_q <= 1'b0;
		end else if (taken) begin
			idx_q <= haddr[9:2];
			// Anything but an aligned word in the low window is ignored
			ok_q <= (haddr[31:10] == 22'h000000) && (haddr[1:0] == 2'h0) &&
				(hsize == GTAP_HSIZE_WORD);
		end
	end

	// Decode, using the page as it stands in the data phase
	assign hit_page = ok_q && (idx_q == GTAP_IDX_PAGE);
	assign low_page = ok_q && !page_q && !hit_page;
	assign hit_ctrl = low_page && (idx_q == GTAP_IDX_CTRL);
	assign hit_addr = low_page && (idx_q == GTAP_IDX_ADDR);
	assign hit_data = low_page && (idx_q == GTAP_IDX_DATA);

	assign wr_phase = ce && (state_q == ST_WRITE);
	assign rd_issue = ce && (state_q == ST_RD_MEM);

	// Transfer sequencing
	always_comb begin
		state_d = ST_IDLE;
		case (state_q)
			ST_IDLE, ST_WRITE, ST_RD_DONE: begin
				if (taken) begin
					state_d = hwrite ? ST_WRITE : ST_RD_MEM;
				end
			end
			ST_RD_MEM: begin
				state_d = ST_RD_LOAD;
			end
			ST_RD_LOAD: begin
				state_d = ST_RD_DONE;
			end
			default: begin
				state_d = ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			state_q <= ST_IDLE;
		end else if (ce) begin
			state_q <= state_d;
		end
	end

	// Reads wait two cycles so the table output register can be used
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hreadyout_q <= 1'b1;
		end else if (ce) begin
			if (taken && !hwrite) begin
				hreadyout_q <= 1'b0;
			end else if (state_q == ST_RD_LOAD) begin
				hreadyout_q <= 1'b1;
			end
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hresp_q <= GTAP_HRESP_OKAY;
		end else begin
			hresp_q <= GTAP_HRESP_OKAY;
		end
	end

	// Control register
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ctrl_q <= GTAP_CTRL_RST;
		end else if (wr_phase && hit_ctrl) begin
			ctrl_q <= hwdata[7:0] & GTAP_CTRL_WR_MASK;
		end
	end

	assign sel = ctrl_q[GTAP_CTRL_SEL_LSB +: 2];

	// Page register, writable from either page
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			page_q <= GTAP_PAGE_RST;
		end else if (wr_phase && hit_page) begin
			page_q <= hwdata[GTAP_PAGE_BIT];
		end
	end

	// Entry pointer
	gtap_addr_ptr u_ptr (
		.hclk(hclk),
		.hresetn(hresetn),
		.ce(ce),
		.load(wr_phase && hit_addr),
		.load_val(hwdata[7:0]),
		.rd_done(rd_issue && hit_data),
		.wr_done(wr_phase && hit_data),
		.inc_mode(ctrl_q[GTAP_CTRL_INC_LSB +: 2]),
		.ptr(ptr)
	);

	// Table routing
	always_comb begin
		tbl_we = 3'h0;
		if (wr_phase && hit_data) begin
			case (sel)
				GTAP_SEL_ALL: tbl_we = 3'h7;
				GTAP_SEL_RED: tbl_we[GTAP_TBL_RED] = 1'b1;
				GTAP_SEL_GRN: tbl_we[GTAP_TBL_GRN] = 1'b1;
				GTAP_SEL_BLU: tbl_we[GTAP_TBL_BLU] = 1'b1;
				default: tbl_we = 3'h0;
			endcase
		end
	end

	// Broadcast selection has no single source, so it reads back red
	always_comb begin
		case (sel)
			GTAP_SEL_GRN: rd_tbl = GTAP_TBL_GRN;
			GTAP_SEL_BLU: rd_tbl = GTAP_TBL_BLU;
			default: rd_tbl = GTAP_TBL_RED;
		endcase
	end

	assign mem_bus.wr_en = tbl_we;
	assign mem_bus.rd_en = rd_issue && hit_data;
	assign mem_bus.rd_tbl = rd_tbl;
	assign mem_bus.addr = ptr;
	assign mem_bus.wdata = hwdata[7:0];

	gtap_table_mem u_mem (
		.hclk(hclk),
		.hresetn(hresetn),
		.ce(ce),
		.port(mem_bus.mem)
	);

	// Read data
	always_comb begin
		rbyte = GTAP_ZERO;
		if (hit_ctrl) begin
			rbyte = ctrl_q;
		end else if (hit_addr) begin
			rbyte = ptr;
		end else if (hit_data) begin
			rbyte = mem_bus.rdata;
		end else if (hit_page) begin
			rbyte = {7'h00, page_q};
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hrdata_q <= 32'h00000000;
		end else if (ce && (state_q == ST_RD_LOAD)) begin
			hrdata_q <= {24'h000000, rbyte};
		end
	end

	// Outputs
	assign hreadyout = hreadyout_q;
	assign hresp = hresp_q;
	assign hrdata = hrdata_q;
	assign gamma_red_en = ctrl_q[GTAP_CTRL_RED_EN];
	assign gamma_green_en = ctrl_q[GTAP_CTRL_GRN_EN];
	assign gamma_blue_en = ctrl_q[GTAP_CTRL_BLU_EN];

	// Checks
	a_read_wait: assert property (@(posedge hclk) disable iff (!hresetn || !ce)
		taken && !hwrite |=> !hreadyout ##1 !hreadyout ##1 hreadyout)
		else $error("read data phase did not take three cycles");

	a_write_ready: assert property (@(posedge hclk) disable iff (!hresetn || !ce)
		taken && hwrite |=> hreadyout)
		else $error("write data phase was stalled");

	a_sel_all_we: assert property (@(posedge hclk) disable iff (!hresetn || !ce)
		wr_phase && hit_data && sel == GTAP_SEL_ALL |-> tbl_we == 3'h7)
		else $error("broadcast write missed a table");

	a_sel_one_we: assert property (@(posedge hclk) disable iff (!hresetn || !ce)
		wr_phase && hit_data && sel != GTAP_SEL_ALL
		|-> $onehot(tbl_we) && tbl_we[rd_tbl] && rd_tbl == sel - 2'h1)
		else $error("single-table write reached the wrong table");

	a_rd_data_path: assert property (@(posedge hclk) disable iff (!hresetn || !ce)
		state_q == ST_RD_LOAD && hit_data |=> hrdata == {24'h000000, $past(mem_bus.rdata)})
		else $error("data port read did not return the table entry");

	a_gamma_enable: assert property (@(posedge hclk) disable iff (!hresetn || !ce)
		wr_phase && hit_ctrl
		|=> {gamma_red_en, gamma_green_en, gamma_blue_en} == $past(hwdata[7:5]))
		else $error("gamma enables did not follow the control write");

	a_page_both: assert property (@(posedge hclk) disable iff (!hresetn || !ce)
		wr_phase && ok_q && idx_q == 8'hff |=> page_q == $past(hwdata[0]))
		else $error("page bit not writable from the current page");

	a_upper_ignored: assert property (@(posedge hclk) disable iff (!hresetn || !ce)
		wr_phase && page_q && !hit_page |=> $stable(ctrl_q) && $stable(ptr))
		else $error("upper page write reached a lower page register");

	// Bus response, read data lifetime and readback, and the clock-enable freeze
	a_resp_okay: assert property (@(posedge hclk) disable iff (!hresetn)
		hresp == GTAP_HRESP_OKAY)
		else $error("slave gave a response other than OKAY");

	a_rdata_hold: assert property (@(posedge hclk) disable iff (!hresetn)
		!(ce && state_q == ST_RD_LOAD) |=> $stable(hrdata))
		else $error("read data changed outside a read load");

	a_addr_readback: assert property (@(posedge hclk) disable iff (!hresetn || !ce)
		state_q == ST_RD_LOAD && hit_addr |=> hrdata == {24'h000000, $past(ptr)})
		else $error("address port read did not return the pointer");

	a_page_readback: assert property (@(posedge hclk) disable iff (!hresetn || !ce)
		state_q == ST_RD_LOAD && hit_page |=> hrdata == {31'h0, $past(page_q)})
		else $error("page register read did not return the page bit");

	a_ce_freeze: assert property (@(posedge hclk) disable iff (!hresetn)
		!ce |=> $stable(state_q) && $stable(hreadyout) && $stable(hrdata) &&
		$stable(ctrl_q) && $stable(page_q) && $stable(ptr))
		else $error("state moved while the clock enable was low");
endmodule : gtap_top
`default_nettype wire

// ---- gtap_pkg.sv ----
// Constants shared by the gamma table access port.
// Assumes an 8-bit indexed register space reached word-wise over AHB-Lite.
package gtap_pkg;
	// Register indexes; the byte address is four times the index
	localparam logic [7:0] GTAP_IDX_CTRL = 8'hf0;
	localparam logic [7:0] GTAP_IDX_ADDR = 8'hf1;
	localparam logic [7:0] GTAP_IDX_DATA = 8'hf2;
	localparam logic [7:0] GTAP_IDX_PAGE = 8'hff;

	// Control register fields
	localparam int GTAP_CTRL_RED_EN = 7;
	localparam int GTAP_CTRL_GRN_EN = 6;
	localparam int GTAP_CTRL_BLU_EN = 5;
	localparam int GTAP_CTRL_INC_LSB = 2;
	localparam int GTAP_CTRL_SEL_LSB = 0;
	localparam logic [7:0] GTAP_CTRL_WR_MASK = 8'hef;

	// Page register field
	localparam int GTAP_PAGE_BIT = 0;

	// Reset values
	localparam logic [7:0] GTAP_CTRL_RST = 8'h00;
	localparam logic [7:0] GTAP_ADDR_RST = 8'h00;
	localparam logic GTAP_PAGE_RST = 1'b0;

	// Auto-increment modes
	localparam logic [1:0] GTAP_INC_NONE = 2'h0;
	localparam logic [1:0] GTAP_INC_RD = 2'h1;
	localparam logic [1:0] GTAP_INC_WR = 2'h2;
	localparam logic [1:0] GTAP_INC_BOTH = 2'h3;

	// Table selection codes
	localparam logic [1:0] GTAP_SEL_ALL = 2'h0;
	localparam logic [1:0] GTAP_SEL_RED = 2'h1;
	localparam logic [1:0] GTAP_SEL_GRN = 2'h2;
	localparam logic [1:0] GTAP_SEL_BLU = 2'h3;

	// Table storage
	localparam int GTAP_NUM_TABLES = 3;
	localparam int GTAP_DEPTH = 256;
	localparam logic [1:0] GTAP_TBL_RED = 2'h0;
	localparam logic [1:0] GTAP_TBL_GRN = 2'h1;
	localparam logic [1:0] GTAP_TBL_BLU = 2'h2;

	// Bus
	localparam logic [2:0] GTAP_HSIZE_WORD = 3'h2;
	localparam logic GTAP_HRESP_OKAY = 1'b0;
	localparam logic [7:0] GTAP_ZERO = 8'h00;
endpackage : gtap_pkg

// ---- gtap_mem_if.sv ----
// Connection between the access logic and the table storage.
// Assumes one driver per modport side, same clock on both.
`timescale 1ns/1ns
`default_nettype none
interface gtap_mem_if;
	logic [gtap_pkg::GTAP_NUM_TABLES-1:0] wr_en;
	logic rd_en;
	logic [1:0] rd_tbl;
	logic [7:0] addr;
	logic [7:0] wdata;
	logic [7:0] rdata;

	modport ctrl (output wr_en, rd_en, rd_tbl, addr, wdata, input rdata);
	modport mem (input wr_en, rd_en, rd_tbl, addr, wdata, output rdata);
endinterface : gtap_mem_if
`default_nettype wire

// ---- gtap_table_mem.sv ----
// Three colour gamma tables with one shared index and registered read data.
// Assumes the access logic never asks for a table index above blue.
`timescale 1ns/1ns
`default_nettype none
module gtap_table_mem
	import gtap_pkg::*;
(
	// Clock and reset
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic ce,
	// Table port
	gtap_mem_if.mem port
);
	logic [7:0] tbl_rd [GTAP_NUM_TABLES];

	genvar t;
	generate
		for (t = 0; t < GTAP_NUM_TABLES; t++) begin : g_tbl
			logic [7:0] cells [GTAP_DEPTH];
			// No reset: contents are undefined until software loads them
			always_ff @(posedge hclk) begin
				if (ce && port.wr_en[t]) begin
					cells[port.addr] <= port.wdata;
				end
			end
			assign tbl_rd[t] = cells[port.addr];
		end
	endgenerate

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			port.rdata <= GTAP_ZERO;
		end else if (ce && port.rd_en) begin
			port.rdata <= tbl_rd[port.rd_tbl];
		end
	end
endmodule : gtap_table_mem
`default_nettype wire

// ---- gtap_addr_ptr.sv ----
// Gamma table entry pointer with load and mode-gated auto-increment.
// Assumes load and the two access strobes come from the same clock.
`timescale 1ns/1ns
`default_nettype none
module gtap_addr_ptr
	import gtap_pkg::*;
(
	// Clock and reset
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic ce,
	// Control
	input wire logic load,
	input wire logic [7:0] load_val,
	input wire logic rd_done,
	input wire logic wr_done,
	input wire logic [1:0] inc_mode,
	// Pointer
	output logic [7:0] ptr
);
	logic step;
	logic [7:0] ptr_q;

	assign step = (rd_done && (inc_mode == GTAP_INC_RD || inc_mode == GTAP_INC_BOTH)) ||
		(wr_done && (inc_mode == GTAP_INC_WR || inc_mode == GTAP_INC_BOTH));
	assign ptr = ptr_q;

	// Natural 8-bit overflow gives the wrap from the last entry to the first
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ptr_q <= GTAP_ADDR_RST;
		end else if (ce) begin
			if (load) begin
				ptr_q <= load_val;
			end else if (step) begin
				ptr_q <= ptr_q + 8'h01;
			end
		end
	end

	a_ptr_load: assert property (@(posedge hclk) disable iff (!hresetn || !ce)
		load |=> ptr == $past(load_val))
		else $error("pointer did not take the written address");

	a_ptr_step: assert property (@(posedge hclk) disable iff (!hresetn || !ce)
		!load && ((wr_done && inc_mode[1]) || (rd_done && inc_mode[0]))
		|=> ptr == $past(ptr) + 8'h01)
		else $error("pointer did not advance after an enabled access");

	a_ptr_hold: assert property (@(posedge hclk) disable iff (!hresetn || !ce)
		!load && !(wr_done && inc_mode[1]) && !(rd_done && inc_mode[0])
		|=> $stable(ptr))
		else $error("pointer moved without an enabled access");

	a_ptr_wrap: assert property (@(posedge hclk) disable iff (!hresetn || !ce)
		!load && ptr == 8'hff && wr_done && inc_mode[1] |=> ptr == 8'h00)
		else $error("pointer did not wrap to zero");
endmodule : gtap_addr_ptr
`default_nettype wire

// ---- gtap_top_bench.sv ----
// Self-checking bench for the gamma table access port top.
// Assumes one AHB-Lite master here, hready looped back from hreadyout.
`timescale 1ns/1ns
`default_nettype none
module gtap_top_bench
	import gtap_pkg::*;
;
	logic hclk = 1'b0;
	logic hresetn = 1'b0;
	logic ce = 1'b1;
	logic hsel = 1'b0;
	logic [31:0] haddr = 32'h0;
	logic [1:0] htrans = 2'h0;
	logic hwrite = 1'b0;
	logic [2:0] hsize = GTAP_HSIZE_WORD;
	logic [31:0] hwdata = 32'h0;
	wire hready;
	logic hreadyout;
	logic hresp;
	logic [31:0] hrdata;
	logic gamma_red_en;
	logic gamma_green_en;
	logic gamma_blue_en;
	int failures = 0;
	int checked = 0;

	assign hready = hreadyout;
	always #4 hclk = ~hclk;

	gtap_top dut (.hclk(hclk), .hresetn(hresetn), .ce(ce), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
		.hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .gamma_red_en(gamma_red_en),
		.gamma_green_en(gamma_green_en), .gamma_blue_en(gamma_blue_en));

	task automatic end_sim;
		if (failures == 0 && checked > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask : end_sim

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp) begin
			failures++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk

	// Single word transfer; waits on hready with no assumed latency
	task automatic bus(input logic wr, input logic [7:0] idx, input logic [7:0] wd,
		output logic [31:0] rd);
		hsel <= 1'b1;
		htrans <= 2'h2;
		hwrite <= wr;
		haddr <= {22'h0, idx, 2'h0};
		do @(posedge hclk); while (hready !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= {24'h0, wd};
		do @(posedge hclk); while (hready !== 1'b1);
		rd = hrdata;
	endtask : bus

	task automatic wr(input logic [7:0] idx, input logic [7:0] v);
		logic [31:0] d;
		bus(1'b1, idx, v, d);
	endtask : wr

	task automatic rchk(input logic [7:0] idx, input logic [7:0] exp);
		logic [31:0] d;
		bus(1'b0, idx, 8'h00, d);
		chk(d, {24'h0, exp});
		chk({31'h0, hresp}, {31'h0, GTAP_HRESP_OKAY});
	endtask : rchk

	task automatic t_reset;
		rchk(GTAP_IDX_CTRL, 8'h00);
		rchk(GTAP_IDX_ADDR, GTAP_ADDR_RST);
		rchk(GTAP_IDX_PAGE, 8'h00);
		chk({29'h0, gamma_red_en, gamma_green_en, gamma_blue_en}, 32'h0);
	endtask : t_reset

	task automatic t_ctrl;
		logic [7:0] v[3] = '{8'hff, 8'ha0, 8'h40};
		for (int i = 0; i < 3; i++) begin
			wr(GTAP_IDX_CTRL, v[i]);
			rchk(GTAP_IDX_CTRL, v[i] & GTAP_CTRL_WR_MASK);
			chk({29'h0, gamma_red_en, gamma_green_en, gamma_blue_en}, {29'h0, v[i][7:5]});
		end
		wr(GTAP_IDX_ADDR, 8'h5a);
		rchk(GTAP_IDX_ADDR, 8'h5a);
	endtask : t_ctrl

	task automatic t_sel;
		wr(GTAP_IDX_CTRL, {4'h0, GTAP_INC_NONE, GTAP_SEL_ALL});
		wr(GTAP_IDX_ADDR, 8'h10);
		wr(GTAP_IDX_DATA, 8'h3c);
		for (int s = 1; s < 4; s++) begin
			wr(GTAP_IDX_CTRL, {6'h0, 2'(s)});
			rchk(GTAP_IDX_DATA, 8'h3c);
		end
		for (int s = 1; s < 4; s++) begin
			wr(GTAP_IDX_CTRL, {6'h0, 2'(s)});
			wr(GTAP_IDX_DATA, 8'(8'h11 * s));
		end
		for (int s = 1; s < 4; s++) begin
			wr(GTAP_IDX_CTRL, {6'h0, 2'(s)});
			rchk(GTAP_IDX_DATA, 8'(8'h11 * s));
		end
		// Select-all reads come back from the red table
		wr(GTAP_IDX_CTRL, {4'h0, GTAP_INC_NONE, GTAP_SEL_ALL});
		rchk(GTAP_IDX_DATA, 8'h11);
	endtask : t_sel

	// Pointer parked at 255 so any advance also proves the wrap to 0
	task automatic t_inc;
		logic [1:0] m;
		for (int i = 0; i < 4; i++) begin
			m = 2'(i);
			wr(GTAP_IDX_CTRL, {4'h0, m, GTAP_SEL_RED});
			wr(GTAP_IDX_ADDR, 8'hff);
			wr(GTAP_IDX_DATA, 8'(8'h70 + i));
			rchk(GTAP_IDX_ADDR, m[1] ? 8'h00 : 8'hff);
			wr(GTAP_IDX_ADDR, 8'hff);
			rchk(GTAP_IDX_DATA, 8'(8'h70 + i));
			rchk(GTAP_IDX_ADDR, m[0] ? 8'h00 : 8'hff);
		end
	endtask : t_inc

	task automatic t_page;
		wr(GTAP_IDX_ADDR, 8'h21);
		rchk(8'h10, 8'h00);
		wr(GTAP_IDX_PAGE, 8'h01);
		rchk(GTAP_IDX_PAGE, 8'h01);
		rchk(GTAP_IDX_ADDR, 8'h00);
		wr(GTAP_IDX_ADDR, 8'h33);
		wr(GTAP_IDX_PAGE, 8'h00);
		rchk(GTAP_IDX_PAGE, 8'h00);
		rchk(GTAP_IDX_ADDR, 8'h21);
	endtask : t_page

	// Enable dropped in a read's wait states must stretch the read, not corrupt it
	task automatic t_ce;
		wr(GTAP_IDX_CTRL, {4'h0, GTAP_INC_RD, GTAP_SEL_GRN});
		wr(GTAP_IDX_ADDR, 8'h10);
		fork
			rchk(GTAP_IDX_DATA, 8'h22);
			begin
				repeat (2) @(posedge hclk);
				ce <= 1'b0;
				repeat (5) begin
					@(posedge hclk);
					chk({31'h0, hreadyout}, 32'h0);
				end
				ce <= 1'b1;
			end
		join
		rchk(GTAP_IDX_ADDR, 8'h11);
	endtask : t_ce

	// A non-word write is dropped without an error response
	task automatic t_size;
		wr(GTAP_IDX_CTRL, 8'h00);
		hsize <= 3'h0;
		wr(GTAP_IDX_CTRL, 8'he0);
		hsize <= GTAP_HSIZE_WORD;
		rchk(GTAP_IDX_CTRL, 8'h00);
		chk({29'h0, gamma_red_en, gamma_green_en, gamma_blue_en}, 32'h0);
	endtask : t_size

	// Reset in mid-run brings every register back to its reset value
	task automatic t_rst2;
		wr(GTAP_IDX_CTRL, 8'he7);
		wr(GTAP_IDX_ADDR, 8'h77);
		wr(GTAP_IDX_PAGE, 8'h01);
		hresetn <= 1'b0;
		repeat (3) @(posedge hclk);
		chk({29'h0, gamma_red_en, gamma_green_en, gamma_blue_en}, 32'h0);
		hresetn <= 1'b1;
		t_reset();
	endtask : t_rst2

	// Whole run is a few hundred cycles; this cuts a stuck handshake short
	initial begin
		#40000;
		failures++;
		end_sim();
	end

	initial begin
		repeat (20) @(posedge hclk);
		hresetn <= 1'b1;
		t_reset();
		t_ctrl();
		t_sel();
		t_inc();
		t_page();
		t_ce();
		t_size();
		t_rst2();
		end_sim();
	end
endmodule : gtap_top_bench
`default_nettype wire
